/* File: dv/ddcd_decoder_properties.sv */
// port assertions for the command decoder
`timescale 1ns/1ps
module ddcd_decoder_properties
	import ddcd_pkg::*;
(
	input logic clk,
	input logic srst,
	input logic frame_n,
	input logic load_strobe_pin,
	input logic [1:0] channel_gain_select,
	input ddcd_pkg::ddcd_pwr_e pwr_mode_a,
	input ddcd_pkg::ddcd_pwr_e pwr_mode_b,
	input logic [1:0] load_mask,
	input logic [1:0] hw_load_active,
	input logic ref_enabled,
	input logic input_reset,
	input logic output_update
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic run;
	// some channel in normal mode
	assign run = pwr_mode_a == DDCD_PWR_NORMAL || pwr_mode_b == DDCD_PWR_NORMAL;
	a_pulse_pair: assert property (input_reset == output_update) else $error("pair");
	a_pulse_once: assert property (input_reset |=> !input_reset) else $error("once");
	a_mask_gate: assert property (!(hw_load_active & load_mask)) else $error("mask");
	a_pin_low: assert property ((!load_strobe_pin)[*4] |-> hw_load_active == ~load_mask)
		else $error("low");
	a_pin_high: assert property (load_strobe_pin[*4] |-> !hw_load_active) else $error("hi");
	a_ref_down: assert property (!run |-> !ref_enabled) else $error("ref");
	a_ref_on: assert property ($rose(ref_enabled) && $stable(run) |-> !channel_gain_select)
		else $error("on");
	a_ref_off: assert property ($fell(ref_enabled) && $stable(run) |-> &channel_gain_select)
		else $error("off");
	a_idle_hold: assert property (frame_n[*8] ##0 !$past(srst) |-> $stable({load_mask,
		channel_gain_select, pwr_mode_a, pwr_mode_b})) else $error("hold");
	cover property (input_reset);
	cover property ($rose(ref_enabled));
	cover property (&hw_load_active);
endmodule : ddcd_decoder_properties

/* File: dv/ddcd_decoder_test.sv */
// self-checking bench for the control command decoder
`timescale 1ns/1ps
module ddcd_decoder_test;
	import ddcd_pkg::*;
	logic clk = 0;
	logic srst = 1;
	logic load_strobe_pin = 1;
	logic link_clk, frame_n, link_data, ref_enabled, input_reset, output_update, r;
	logic [1:0] channel_gain_select, load_mask, hw_load_active, g, m, a, b;
	ddcd_pwr_e pwr_mode_a, pwr_mode_b;
	logic [8:0] q[$];
	int err_total, samples_checked, cyc, pulse_total;
	logic [8:0] seen_state;
	event smp;
	ddcd_host_model ddcd_host_model_i (.*);
	ddcd_decoder ddcd_decoder_i (.*);
	initial
		forever #20 clk = ~clk;
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	// send one word with random don't-care bits, note the expected state
	task automatic go(input logic [2:0] c, input logic [2:0] ad, input logic [5:0] d);
		logic [23:0] w;
		w = 24'($urandom);
		{w[21:16], w[5:4], w[1:0]} = {c, ad, d[5:4], d[1:0]};
		if (c == 3'h0 && ad == 3'h2) g = d[1:0];
		if (c == 3'h4 && d[0]) a = d[5:4];
		if (c == 3'h4 && d[1]) b = d[5:4];
		if (c == 3'h5 && d[0]) {g, a, b, m, r} = 9'h180;
		if (c == 3'h6) m = d[1:0];
		if (c == 3'h7) {r, g} = {d[0], {2{~d[0]}}};
		q.push_back({g, a, b, m, r && (a == 2'h0 || b == 2'h0)});
		ddcd_host_model_i.send(w, 24);
		repeat (8) @(negedge clk);
		->smp;
	endtask : go
	// compare settled outputs with the oldest note
	assign seen_state = {channel_gain_select, pwr_mode_a, pwr_mode_b, load_mask, ref_enabled};
	always @(smp)
		check(seen_state, q.pop_front());
	// random strobe level and cycle ceiling
	always @(negedge clk)
	begin
		cyc++;
		if (input_reset && output_update)
			pulse_total++;
		if (cyc % 16 == 0)
			load_strobe_pin <= 1'($urandom);
		if (cyc == 20000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
	// main sequence
	initial
	begin
		void'($urandom(66470));
		{g, a, b, m, r} = 9'h180;
		repeat (2) @(negedge clk);
		srst = 0;
		go(3'h1, 3'h2, 6'h3);
		go(3'h0, 3'h2, 6'h1);
		go(3'h0, 3'h2, 6'h2);
		go(3'h0, 3'h3, 6'h3);
		ddcd_host_model_i.send(24'h020003, 12);
		go(3'h3, 3'h2, 6'h3);
		for (int i = 0; i < 16; i++)
			go(3'h4, 3'($urandom), 6'({i[3:2], 2'h0, i[1:0]}));
		go(3'h7, 3'h0, 6'h1);
		go(3'h4, 3'h0, 6'h1);
		go(3'h7, 3'h0, 6'h0);
		go(3'h7, 3'h0, 6'h1);
		go(3'h0, 3'h2, 6'h2);
		for (int i = 0; i < 4; i++)
			go(3'h6, 3'h5, 6'(i));
		check(9'(pulse_total), 9'h0);
		go(3'h5, 3'h1, 6'h3e);
		check(9'(pulse_total), 9'h1);
		go(3'h5, 3'h1, 6'h1);
		check(9'(pulse_total), 9'h2);
		tally_and_finish();
	end
endmodule : ddcd_decoder_test
bind ddcd_decoder ddcd_decoder_properties ddcd_decoder_properties_i (.*);

/* File: dv/ddcd_host_model.sv */
// serial host model: sends command words msb first
`timescale 1ns/1ps
module ddcd_host_model (
	output logic link_clk = 1'b1,
	output logic frame_n = 1'b1,
	output logic link_data = 1'b0
);
	// shift n bits of w, clock stands high between frames
	task automatic send(input logic [23:0] w, input int n);
		frame_n = 1'b0;
		for (int i = 23; i > 23 - n; i--)
		begin
			link_data = w[i];
			#160 link_clk = 1'b0;
			#160 link_clk = 1'b1;
		end
		frame_n = 1'b1;
		link_data = ~link_data;
		#400;
	endtask : send
endmodule : ddcd_host_model

/* File: hw/ddcd_decoder.sv */
// control command decoder for a dual voltage-output converter
// Overview of operation
// - command code in bits 21 to 19
// - gain written by command 000, address 010
// - gain bit 0 is two, 1 is one
// - both gain bits reset to one
// - gain bits map to each channel independently
// - reference on/off forces both gains
// - command 111 bit 0 sets reference, gains
// - power field in data bits 5 and 4
// - field 00 powers up selected channels
// - field 01 powers down with 1k
// - field 10 powers down with 100k
// - field 11 powers down high impedance
// - unselected channel keeps its mode
// - reset bit 0 clear: input registers reset
// - reset bit 0 set: full power-on reset
// - mask bit 1 disables load strobe pin
// - mask 00 all active, 11 none
// - don't-care bits never affect decoding
// - reference off while both channels down
`timescale 1ns/1ps
`include "ddcd_consts.svh"
module ddcd_decoder
	import ddcd_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic link_clk,
	input wire logic frame_n,
	input wire logic link_data,
	input wire logic load_strobe_pin,
	output logic [1:0] channel_gain_select,
	output ddcd_pkg::ddcd_pwr_e pwr_mode_a,
	output ddcd_pkg::ddcd_pwr_e pwr_mode_b,
	output logic [1:0] load_mask,
	output logic [1:0] hw_load_active,
	output logic ref_enabled,
	output logic input_reset,
	output logic output_update
);
	import ddcd_pkg::*;
	typedef struct packed {
		logic [1:0] gain;
		ddcd_pwr_e pwr_a;
		ddcd_pwr_e pwr_b;
		logic [1:0] mask;
		logic ref_req;
		logic input_reset;
		logic output_update;
		logic [1:0] ld_sync;
		logic ref_out; // registered reference enable
		logic [1:0] ld_act; // registered strobe reach per channel
	} ddcd_state_s;
	ddcd_state_s st;
	ddcd_state_s next_st;
	ddcd_word_t word;
	logic word_valid;
	logic [2:0] cmd;
	logic [2:0] addr;
	ddcd_pwr_e pfield;

	// channel power-mode update for one channel
	function automatic ddcd_pwr_e ddcd_pwr_next(input logic sel, input ddcd_pwr_e cur,
		input ddcd_pwr_e fld);
		ddcd_pwr_e r;
		r = cur; // unselected channel unchanged
		if (sel)
		begin
			r = fld;
		end
		return r;
	endfunction : ddcd_pwr_next

	// three-bit field of a command word starting at bit lo
	function automatic logic [2:0] ddcd_field3(input ddcd_word_t w, input int lo);
		logic [2:0] f;
		f = w[lo +: 3];
		return f;
	endfunction : ddcd_field3

	// power-on register values, shared by the reset input and the full software reset
	function automatic ddcd_state_s ddcd_power_on_state();
		ddcd_state_s s;
		s = '0;
		s.gain = `DDCD_GAIN_RESET; // both channels gain one
		s.pwr_a = DDCD_PWR_NORMAL;
		s.pwr_b = DDCD_PWR_NORMAL;
		s.mask = `DDCD_MASK_RESET;
		s.ref_req = `DDCD_REF_RESET;
		s.ld_sync = 2'h3; // strobe pin idles high
		return s;
	endfunction : ddcd_power_on_state

	// gains forced by a reference command: on selects two, off selects one
	function automatic logic [1:0] ddcd_forced_gain(input logic ref_on);
		logic [1:0] g;
		g = `DDCD_GAIN_RESET;
		if (ref_on)
		begin
			g = `DDCD_GAIN_ALL_TWO;
		end
		return g;
	endfunction : ddcd_forced_gain

	// reference may run only while some channel is in normal mode
	function automatic logic ddcd_ref_allowed(input ddcd_pwr_e pa, input ddcd_pwr_e pb);
		logic ok;
		ok = (pa == DDCD_PWR_NORMAL) || (pb == DDCD_PWR_NORMAL);
		return ok;
	endfunction : ddcd_ref_allowed

	// strobe reaches a channel only when its mask bit is clear and the pin is low
	function automatic logic [1:0] ddcd_strobe_gate(input logic [1:0] mask, input logic pin_sync);
		logic [1:0] act;
		act = ~mask & {2{~pin_sync}};
		return act;
	endfunction : ddcd_strobe_gate

	// serial receiver
	ddcd_shift_in ddcd_shift_in_i (
		.clk(clk),
		.srst(srst),
		.link_clk(link_clk),
		.frame_n(frame_n),
		.link_data(link_data),
		.word(word),
		.word_valid(word_valid)
	);

	// field extraction; bits 23..22 and other don't-cares are never read
	assign cmd = ddcd_field3(word, `DDCD_CMD_LO);
	assign addr = ddcd_field3(word, `DDCD_ADDR_LO);
	assign pfield = ddcd_pwr_e'(word[`DDCD_PWR_HI:`DDCD_PWR_LO]);

	// command decode
	always_comb
	begin
		next_st = st;
		// pulses clear unless a reset command raises them
		next_st.input_reset = 1'b0;
		next_st.output_update = 1'b0;
		next_st.ld_sync = {st.ld_sync[0], load_strobe_pin}; // strobe pin two-flop sync
		if (word_valid)
		begin
			case (cmd)
				// gain register write, only through the gain address
				`DDCD_CMD_WRITE_IN:
				begin
					if (addr == `DDCD_ADDR_GAIN) // others leave gain alone
					begin
						next_st.gain = word[1:0]; // bit1 second, bit0 first
					end
				end
				// power mode for each selected channel
				`DDCD_CMD_POWER:
				begin
					next_st.pwr_b = ddcd_pwr_next(word[1], st.pwr_b, pfield);
					next_st.pwr_a = ddcd_pwr_next(word[0], st.pwr_a, pfield);
				end
				// software reset, bit 0 chooses the full scope
				`DDCD_CMD_SWRESET:
				begin
					if (word[0])
					begin
						next_st = ddcd_power_on_state();
						next_st.ld_sync = {st.ld_sync[0], load_strobe_pin}; // sync keeps running
					end
					next_st.input_reset = 1'b1;
					next_st.output_update = 1'b1;
				end
				// load strobe mask, one bit per channel
				`DDCD_CMD_LDMASK:
				begin
					next_st.mask = word[1:0];
				end
				// reference switch, which also forces both gains
				`DDCD_CMD_REFCTL:
				begin
					next_st.ref_req = word[0];
					next_st.gain = ddcd_forced_gain(word[0]);
				end
				// data writes and updates belong to other logic
				default:
				begin
					next_st.input_reset = 1'b0;
				end
			endcase
		end
		// derived outputs registered from next-state values, so they move with the registers
		next_st.ref_out = next_st.ref_req
			& ddcd_ref_allowed(next_st.pwr_a, next_st.pwr_b);
		next_st.ld_act = ddcd_strobe_gate(next_st.mask, next_st.ld_sync[1]);
	end

	// state register, power-on values
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st <= ddcd_power_on_state();
		end
		else
		begin
			st <= next_st;
		end
	end

	// outputs
	assign channel_gain_select = st.gain;
	assign pwr_mode_a = st.pwr_a;
	assign pwr_mode_b = st.pwr_b;
	assign load_mask = st.mask;
	assign hw_load_active = st.ld_act; // pin low loads unmasked
	// reference only while some channel is normal
	assign ref_enabled = st.ref_out;
	// reset pulses, one cycle each
	assign input_reset = st.input_reset;
	assign output_update = st.output_update;
endmodule : ddcd_decoder

/* File: hw/ddcd_shift_in.sv */
// serial word receiver: synchronises link pins and emits completed 24-bit words
`timescale 1ns/1ps
`include "ddcd_consts.svh"
module ddcd_shift_in
	import ddcd_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic link_clk,
	input wire logic frame_n,
	input wire logic link_data,
	output ddcd_pkg::ddcd_word_t word,
	output logic word_valid
);
	import ddcd_pkg::*;
	typedef struct packed {
		logic [1:0] clk_sync;
		logic [1:0] frame_sync;
		logic [1:0] data_sync;
		logic clk_prev;
		logic [4:0] count;
		ddcd_word_t shreg;
		ddcd_word_t word;
		logic word_valid;
	} ddcd_rx_s;
	ddcd_rx_s st;
	ddcd_rx_s next_st;
	// shift on falling link clock edges while frame is low
	always_comb
	begin
		next_st = st;
		next_st.clk_sync = {st.clk_sync[0], link_clk};
		next_st.frame_sync = {st.frame_sync[0], frame_n};
		next_st.data_sync = {st.data_sync[0], link_data};
		next_st.clk_prev = st.clk_sync[1];
		next_st.word_valid = 1'b0;
		if (st.frame_sync[1])
		begin
			next_st.count = 5'h0; // frame abort discards partial word
		end
		else if (st.clk_prev && !st.clk_sync[1])
		begin
			next_st.shreg = {st.shreg[22:0], st.data_sync[1]};
			if (st.count == 5'(`DDCD_WORD_BITS - 1))
			begin
				next_st.word = {st.shreg[22:0], st.data_sync[1]}; // only full words pass
				next_st.word_valid = 1'b1;
				next_st.count = 5'h0;
			end
			else
			begin
				next_st.count = st.count + 5'h1;
			end
		end
	end
	// state register
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st <= '0;
			st.clk_sync <= 2'h3;
			st.clk_prev <= 1'b1;
			st.frame_sync <= 2'h3;
		end
		else
		begin
			st <= next_st;
		end
	end
	assign word = st.word;
	assign word_valid = st.word_valid;
endmodule : ddcd_shift_in

/* File: include/ddcd_consts.svh */
// constants for the dual converter control command decoder
`ifndef DDCD_CONSTS_SVH
`define DDCD_CONSTS_SVH
`define DDCD_WORD_BITS 24
`define DDCD_CMD_HI 21
`define DDCD_CMD_LO 19
`define DDCD_ADDR_HI 18
`define DDCD_ADDR_LO 16
`define DDCD_PWR_HI 5
`define DDCD_PWR_LO 4
`define DDCD_CMD_WRITE_IN 3'h0
`define DDCD_CMD_POWER 3'h4
`define DDCD_CMD_SWRESET 3'h5
`define DDCD_CMD_LDMASK 3'h6
`define DDCD_CMD_REFCTL 3'h7
`define DDCD_ADDR_GAIN 3'h2
`define DDCD_GAIN_RESET 2'h3
`define DDCD_GAIN_ALL_TWO 2'h0
`define DDCD_MASK_RESET 2'h0
`define DDCD_REF_RESET 1'h0
`define DDCD_LINK_PERIOD_NS 320
`endif

/* File: include/ddcd_pkg.sv */
// types for the dual converter control command decoder
package ddcd_pkg;
	typedef enum logic [1:0] {
		DDCD_PWR_NORMAL = 2'h0,
		DDCD_PWR_PD_1K = 2'h1,
		DDCD_PWR_PD_100K = 2'h2,
		DDCD_PWR_HIGH_IMPEDANCE = 2'h3
	} ddcd_pwr_e;
	typedef logic [23:0] ddcd_word_t;
endpackage : ddcd_pkg
